// *** common/pmpb_pkg.sv ***
/*
 * pmpb_pkg: constants, masks and state type for the power mode and
 * push-button controller.
 * assumes a 100 MHz core clock; analog comparators deliver clean levels.
 */
package pmpb_pkg;

	// ==========================================================
	// clock and timing
	localparam int unsigned     CLK_PERIOD_NS     = 10;
	localparam int unsigned     LONG_PRESS_MS     = 4000;
	localparam longint unsigned LONG_PRESS_CYCLES =
		longint'(LONG_PRESS_MS) * 64'd1000000 / longint'(CLK_PERIOD_NS);
	localparam int unsigned     RESET_TMO_MS      = 64;
	localparam longint unsigned RESET_TMO_CYCLES  =
		longint'(RESET_TMO_MS) * 64'd1000000 / longint'(CLK_PERIOD_NS);
	localparam int unsigned     PC_OFF_MS         = 100;
	localparam longint unsigned PC_OFF_CYCLES     =
		longint'(PC_OFF_MS) * 64'd1000000 / longint'(CLK_PERIOD_NS);
	localparam int unsigned     LED_PERIOD_MS     = 4000;
	localparam int unsigned     LED_STEPS         = 16;
	localparam longint unsigned LED_STEP_CYCLES   =
		longint'(LED_PERIOD_MS) * 64'd1000000 / longint'(CLK_PERIOD_NS) / LED_STEPS;

	// ==========================================================
	// regulator enables, bit n-1 is regulator n, bit 12 always-on
	localparam int unsigned REG_COUNT  = 13;
	localparam logic [12:0] MASK_ALL   = 13'h1FFF;
	localparam logic [12:0] MASK_SLEEP = 13'h1861;
	localparam logic [12:0] MASK_AON   = 13'h1000;
	localparam logic [12:0] MASK_OFF   = 13'h0000;
	localparam logic [12:0] REG_EN_RST = 13'h0000;

	// ==========================================================
	// synchroniser lanes
	localparam int unsigned SYNC_W       = 6;
	localparam int unsigned SYNC_HOLD    = 0;
	localparam int unsigned SYNC_ENABLE  = 1;
	localparam int unsigned SYNC_PB_N    = 2;
	localparam int unsigned SYNC_LOW_IMP = 3;
	localparam int unsigned SYNC_AUX_HI  = 4;
	localparam int unsigned SYNC_AUX_LO  = 5;
	localparam logic [5:0]  SYNC_RST_VAL = 6'h04;

	// ==========================================================
	// sequencer states
	typedef enum logic [2:0] {
		ST_POR,
		ST_RUN,
		ST_PRESS,
		ST_SOFT,
		ST_PCOFF
	} pmpb_state_t;

endpackage

// *** verilog/pmpb_sync.sv ***
/*
 * pmpb_sync: two-flop level synchroniser, one lane per bit.
 * assumes each lane is a slow level; no pulse survives the crossing.
 */
`timescale 1ns/100ps
module pmpb_sync #(
	parameter int unsigned WIDTH   = 6,
	parameter logic [5:0]  RST_VAL = 6'h00
) (
	input  wire logic             core_clk,
	input  wire logic             sys_rst,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);

	logic [WIDTH-1:0] stage1;

	generate
		if (WIDTH < 1 || WIDTH > 6) begin : g_bad_width
			$error("pmpb_sync width out of range");
		end
	endgenerate

	// ==========================================================
	// two flops per lane
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			stage1   <= RST_VAL[WIDTH-1:0];
			sync_out <= RST_VAL[WIDTH-1:0];
		end else begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end

endmodule

// *** verilog/pmpb_ctrl.sv ***
/*
 * pmpb_ctrl: power mode selection, push-button decode, manual reset
 * timing and led pwm duty for a multi-rail power unit.
 * assumes comparators for button impedance and aux rail thresholds,
 * and a host driving hold and enable as levels.
 */
// Behaviour
// - hold and enable are level inputs; their combination picks the mode
// - hold and enable both high: every regulator on
// - hold only: regulators 1, 6, 7, 12 and always-on stay on
// - neither: always-on only above 2.6V aux rail, all off below 2.2V
// - led duty code 0 gives one sixteenth, code 15 full on
// - button serves enable or manual reset, chosen by pull-down impedance
// - internal timer measures how long a manual reset lasts
// - under 4 s soft reset and flag; longer power cycles and flags
// - soft reset drives reset low until release and timeout
`timescale 1ns/100ps
module pmpb_ctrl #(
	parameter int unsigned LONG_PRESS_CYC = 32'(pmpb_pkg::LONG_PRESS_CYCLES),
	parameter int unsigned RESET_TMO_CYC  = 32'(pmpb_pkg::RESET_TMO_CYCLES),
	parameter int unsigned PC_OFF_CYC     = 32'(pmpb_pkg::PC_OFF_CYCLES),
	parameter int unsigned LED_STEP_CYC   = 32'(pmpb_pkg::LED_STEP_CYCLES)
) (
	input  wire logic        core_clk,
	input  wire logic        sys_rst,
	input  wire logic        power_hold_in,
	input  wire logic        power_enable_in,
	input  wire logic        pushbutton_in_n,
	input  wire logic        pb_low_impedance,
	input  wire logic        aux_rail_above_hi,
	input  wire logic        aux_rail_below_lo,
	input  wire logic [3:0]  led_duty_code,
	input  wire logic        soft_flag_read,
	input  wire logic        cycle_flag_read,
	output logic      [12:0] reg_enable,
	output logic             reset_out_n,
	output logic             reset_out_oe,
	output logic             soft_reset_flag,
	output logic             power_cycle_flag,
	output logic             led_pwm_out
);

	// ==========================================================
	// parameter checks
	generate
		if (LONG_PRESS_CYC < 2 || RESET_TMO_CYC < 1 || PC_OFF_CYC < 1 || LED_STEP_CYC < 1) begin : g_bad
			$error("pmpb_ctrl timing parameter too small");
		end
	endgenerate

	// ==========================================================
	// input synchronisers
	logic [5:0] raw_in;
	logic [5:0] sync_in;

	assign raw_in = {aux_rail_below_lo, aux_rail_above_hi, pb_low_impedance,
		pushbutton_in_n, power_enable_in, power_hold_in};

	pmpb_sync #(
		.WIDTH   (pmpb_pkg::SYNC_W),
		.RST_VAL (pmpb_pkg::SYNC_RST_VAL)
	) u_sync (
		.core_clk (core_clk),
		.sys_rst  (sys_rst),
		.async_in (raw_in),
		.sync_out (sync_in)
	);

	wire hold_s    = sync_in[pmpb_pkg::SYNC_HOLD];
	wire enable_s  = sync_in[pmpb_pkg::SYNC_ENABLE];
	wire pb_n_s    = sync_in[pmpb_pkg::SYNC_PB_N];
	wire low_imp_s = sync_in[pmpb_pkg::SYNC_LOW_IMP];
	wire aux_hi_s  = sync_in[pmpb_pkg::SYNC_AUX_HI];
	wire aux_lo_s  = sync_in[pmpb_pkg::SYNC_AUX_LO];

	// ==========================================================
	// button decode
	wire press    = ~pb_n_s;
	wire mr_press = press & low_imp_s;
	wire en_press = press & ~low_imp_s;

	// ==========================================================
	// aux rail hysteresis
	logic rail_ok;
	wire  next_rail_ok = aux_hi_s ? 1'b1 : (aux_lo_s ? 1'b0 : rail_ok);

	// ==========================================================
	// mode decode
	// level combination decode
	wire eff_hold   = hold_s | en_press;
	wire eff_enable = enable_s | en_press;
	logic [12:0] mode_mask;
	assign mode_mask = (eff_hold && eff_enable) ? pmpb_pkg::MASK_ALL :
		eff_hold ? pmpb_pkg::MASK_SLEEP :
		rail_ok ? pmpb_pkg::MASK_AON : pmpb_pkg::MASK_OFF;

	// ==========================================================
	// reset sequencer
	pmpb_pkg::pmpb_state_t state;
	pmpb_pkg::pmpb_state_t next_state;
	logic [31:0]           cnt;
	logic [31:0]           next_cnt;
	logic                  set_soft;
	logic                  set_cycle;

	wire [31:0] cnt_inc = cnt + 32'h00000001;

	always_comb begin
		next_state = state;
		next_cnt   = cnt_inc;
		set_soft   = 1'b0;
		set_cycle  = 1'b0;
		case (state)
			pmpb_pkg::ST_POR: begin
				if (cnt >= RESET_TMO_CYC - 1) begin
					next_state = pmpb_pkg::ST_RUN;
					next_cnt   = 32'h00000000;
				end
			end
			pmpb_pkg::ST_RUN: begin
				next_cnt = 32'h00000000;
				if (mr_press) begin
					next_state = pmpb_pkg::ST_PRESS;
				end
			end
			pmpb_pkg::ST_PRESS: begin
				if (press && cnt >= LONG_PRESS_CYC - 1) begin
					next_state = pmpb_pkg::ST_PCOFF;
					next_cnt   = 32'h00000000;
					set_cycle  = 1'b1;
				end else if (!press) begin
					next_state = pmpb_pkg::ST_SOFT;
					next_cnt   = 32'h00000000;
					set_soft   = 1'b1;
				end
			end
			pmpb_pkg::ST_SOFT: begin
				if (press) begin
					next_cnt = 32'h00000000;
				end else if (cnt >= RESET_TMO_CYC - 1) begin
					next_state = pmpb_pkg::ST_RUN;
					next_cnt   = 32'h00000000;
				end
			end
			pmpb_pkg::ST_PCOFF: begin
				if (cnt >= PC_OFF_CYC - 1) begin
					next_cnt = cnt;
					if (!press) begin
						next_state = pmpb_pkg::ST_POR;
						next_cnt   = 32'h00000000;
					end
				end
			end
			default: begin
				next_state = pmpb_pkg::ST_POR;
				next_cnt   = 32'h00000000;
			end
		endcase
	end

	wire [12:0] next_reg_enable = (next_state == pmpb_pkg::ST_PCOFF) ?
		pmpb_pkg::MASK_OFF : mode_mask;
	wire next_reset_n = (next_state == pmpb_pkg::ST_RUN);
	wire next_soft    = set_soft | (soft_reset_flag & ~soft_flag_read);
	wire next_cycle   = set_cycle | (power_cycle_flag & ~cycle_flag_read);

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			state            <= pmpb_pkg::ST_POR;
			cnt              <= 32'h00000000;
			rail_ok          <= 1'b0;
			reg_enable       <= pmpb_pkg::REG_EN_RST;
			reset_out_n      <= 1'b0;
			soft_reset_flag  <= 1'b0;
			power_cycle_flag <= 1'b0;
		end else begin
			state            <= next_state;
			cnt              <= next_cnt;
			rail_ok          <= next_rail_ok;
			reg_enable       <= next_reg_enable;
			reset_out_n      <= next_reset_n;
			soft_reset_flag  <= next_soft;
			power_cycle_flag <= next_cycle;
		end
	end

	assign reset_out_oe = ~reset_out_n;

	// ==========================================================
	// led pwm
	logic [31:0] step_cnt;
	logic [3:0]  phase;
	wire         step_end      = (step_cnt >= LED_STEP_CYC - 1);
	wire [31:0]  next_step_cnt = step_end ? 32'h00000000 : step_cnt + 32'h00000001;
	wire [3:0]   next_phase    = step_end ? phase + 4'h1 : phase;
	wire         next_led      = (phase <= led_duty_code);

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			step_cnt    <= 32'h00000000;
			phase       <= 4'h0;
			led_pwm_out <= 1'b0;
		end else begin
			step_cnt    <= next_step_cnt;
			phase       <= next_phase;
			led_pwm_out <= next_led;
		end
	end

	// ==========================================================
	// checks
	logic [1:0] rst_age;
	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			rst_age <= 2'h0;
		end else if (rst_age != 2'h3) begin
			rst_age <= rst_age + 2'h1;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	sequence s_short_release;
		state == pmpb_pkg::ST_PRESS && !press;
	endsequence
	sequence s_long_hit;
		state == pmpb_pkg::ST_PRESS && press && cnt == LONG_PRESS_CYC - 1;
	endsequence

	full_on_mask_a: assert property (hold_s && enable_s && state != pmpb_pkg::ST_PCOFF
		&& next_state != pmpb_pkg::ST_PCOFF |=> reg_enable == pmpb_pkg::MASK_ALL)
		else $error("full on mask wrong");
	sleep_mask_a: assert property (hold_s && !enable_s && !en_press
		&& next_state != pmpb_pkg::ST_PCOFF |=> reg_enable == pmpb_pkg::MASK_SLEEP)
		else $error("sleep mask wrong");
	shutdown_mask_a: assert property (!hold_s && !en_press
		&& next_state != pmpb_pkg::ST_PCOFF |=> reg_enable ==
		($past(rail_ok) ? pmpb_pkg::MASK_AON : pmpb_pkg::MASK_OFF))
		else $error("shutdown mask wrong");
	rail_low_a: assert property (aux_lo_s && !aux_hi_s |=> !rail_ok)
		else $error("rail low not seen");
	led_duty_a: assert property (phase == 4'h0 || led_duty_code == 4'hF |=> led_pwm_out)
		else $error("led duty wrong");
	press_route_a: assert property (state == pmpb_pkg::ST_RUN && mr_press
		|=> state == pmpb_pkg::ST_PRESS && !reset_out_n)
		else $error("reset press not taken");
	enable_press_a: assert property (state == pmpb_pkg::ST_RUN && en_press
		|=> state == pmpb_pkg::ST_RUN)
		else $error("enable press taken as reset");
	long_press_a: assert property (s_long_hit |=> state == pmpb_pkg::ST_PCOFF
		&& power_cycle_flag && reg_enable == pmpb_pkg::MASK_OFF)
		else $error("long press not power cycled");
	short_press_a: assert property (s_short_release |=> state == pmpb_pkg::ST_SOFT
		&& soft_reset_flag ##1 !reset_out_n)
		else $error("short press not soft reset");
	soft_hold_a: assert property (state == pmpb_pkg::ST_SOFT && press
		|=> !reset_out_n && cnt == 32'h00000000)
		else $error("soft reset released early");
	sync_delay_a: assert property (rst_age == 2'h3 |-> hold_s == $past(power_hold_in, 2)
		&& enable_s == $past(power_enable_in, 2))
		else $error("sync delay wrong");

endmodule

// *** tb/pmpb_host_model.sv ***
/*
 * pmpb_host_model: host processor and push-button stand-in.
 * assumes the bench sets the request lines; outputs move on core_clk.
 */
`timescale 1ns/100ps
module pmpb_host_model (
	input  wire logic core_clk,
	input  wire logic want_hold,
	input  wire logic want_enable,
	input  wire logic want_press,
	input  wire logic want_mr,
	output logic      power_hold_in = 1'b0,
	output logic      power_enable_in = 1'b0,
	output logic      pushbutton_in_n = 1'b1,
	output logic      pb_low_impedance = 1'b0
);
	// ======
	// host levels
	// plain levels, both high for full on
	always @(posedge core_clk) begin
		power_hold_in <= want_hold;
		power_enable_in <= want_enable;
	end
	// low impedance for reset, resistor for enable
	always @(posedge core_clk) begin
		pushbutton_in_n <= ~want_press;
		pb_low_impedance <= want_press & want_mr;
	end
endmodule

// *** tb/pmpb_ctrl_tb.sv ***
/*
 * pmpb_ctrl_tb: self-checking bench for the power mode controller.
 * assumes short timing parameters and the host model on the pins.
 */
`timescale 1ns/100ps
module pmpb_ctrl_tb;
	// ======
	// signals
	logic        core_clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        want_hold = 1'b0;
	logic        want_enable = 1'b0;
	logic        want_press = 1'b0;
	logic        want_mr = 1'b0;
	logic        above_hi = 1'b1;
	logic        below_lo = 1'b0;
	logic [3:0]  led_duty_code = 4'h0;
	logic        soft_flag_read = 1'b0;
	logic        cycle_flag_read = 1'b0;
	logic        hold_pin;
	logic        enable_pin;
	logic        button_n;
	logic        low_imp;
	logic [12:0] reg_enable;
	logic        reset_out_n;
	logic        reset_out_oe;
	logic        soft_reset_flag;
	logic        power_cycle_flag;
	logic        led_pwm_out;
	int          failures = 0;
	int          check_count = 0;
	int          n;

	initial forever #5 core_clk = ~core_clk;

	pmpb_host_model u_pmpb_host_model (
		.core_clk        (core_clk),
		.want_hold       (want_hold),
		.want_enable     (want_enable),
		.want_press      (want_press),
		.want_mr         (want_mr),
		.power_hold_in   (hold_pin),
		.power_enable_in (enable_pin),
		.pushbutton_in_n (button_n),
		.pb_low_impedance(low_imp)
	);

	pmpb_ctrl #(
		.LONG_PRESS_CYC(20),
		.RESET_TMO_CYC (5),
		.PC_OFF_CYC    (5),
		.LED_STEP_CYC  (2)
	) u_pmpb_ctrl (
		.core_clk         (core_clk),
		.sys_rst          (sys_rst),
		.power_hold_in    (hold_pin),
		.power_enable_in  (enable_pin),
		.pushbutton_in_n  (button_n),
		.pb_low_impedance (low_imp),
		.aux_rail_above_hi(above_hi),
		.aux_rail_below_lo(below_lo),
		.led_duty_code    (led_duty_code),
		.soft_flag_read   (soft_flag_read),
		.cycle_flag_read  (cycle_flag_read),
		.reg_enable       (reg_enable),
		.reset_out_n      (reset_out_n),
		.reset_out_oe     (reset_out_oe),
		.soft_reset_flag  (soft_reset_flag),
		.power_cycle_flag (power_cycle_flag),
		.led_pwm_out      (led_pwm_out)
	);

	// ======
	// helpers
	task automatic check_bit(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("Error %0t: bit %b exp %b", $time, got, exp);
		end
	endtask
	task automatic check_vec(input logic [12:0] got, input logic [12:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("Error %0t: value %h exp %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge core_clk);
		#1;
	endtask
	task automatic complete_run();
		$display("failures %0d checks %0d", failures, check_count);
		if (failures == 0 && check_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic set_mode(input logic h, e, p, m);
		@(posedge core_clk);
		want_hold <= h;
		want_enable <= e;
		want_press <= p;
		want_mr <= m;
		cyc(6);
	endtask
	task automatic wait_release(input int bound);
		n = 0;
		while (reset_out_n !== 1'b1) begin
			cyc(1);
			n++;
			if (n > bound) begin
				failures++;
				$display("Error %0t: reset stuck low", $time);
				complete_run();
			end
		end
	endtask
	task automatic clear_flags(input logic s, c);
		@(posedge core_clk);
		soft_flag_read <= s;
		cycle_flag_read <= c;
		@(posedge core_clk);
		soft_flag_read <= 1'b0;
		cycle_flag_read <= 1'b0;
		cyc(2);
	endtask

	// ======
	// scenarios
	task automatic modes_test();
		set_mode(1, 1, 0, 0);
		check_vec(reg_enable, 13'h1FFF);
		set_mode(1, 0, 0, 0);
		check_vec(reg_enable, 13'h1861);
		set_mode(0, 1, 0, 0);
		check_vec(reg_enable, 13'h1000);
		set_mode(0, 0, 0, 0);
		check_vec(reg_enable, 13'h1000);
		@(posedge core_clk);
		above_hi <= 1'b0;
		cyc(6);
		check_vec(reg_enable, 13'h1000);
		@(posedge core_clk);
		below_lo <= 1'b1;
		cyc(6);
		check_vec(reg_enable, 13'h0000);
		@(posedge core_clk);
		below_lo <= 1'b0;
		above_hi <= 1'b1;
		cyc(6);
		check_vec(reg_enable, 13'h1000);
	endtask
	task automatic short_press_test();
		set_mode(1, 1, 0, 0);
		set_mode(1, 1, 1, 1);
		check_bit(reset_out_n, 1'b0);
		check_bit(reset_out_oe, 1'b1);
		set_mode(1, 1, 0, 0);
		check_bit(soft_reset_flag, 1'b1);
		check_bit(reset_out_n, 1'b0);
		wait_release(20);
		check_bit(power_cycle_flag, 1'b0);
		check_vec(reg_enable, 13'h1FFF);
		clear_flags(1, 0);
		check_bit(soft_reset_flag, 1'b0);
	endtask
	task automatic long_press_test();
		set_mode(1, 1, 1, 1);
		cyc(24);
		check_vec(reg_enable, 13'h0000);
		check_bit(power_cycle_flag, 1'b1);
		check_bit(soft_reset_flag, 1'b0);
		set_mode(1, 1, 0, 0);
		wait_release(40);
		check_vec(reg_enable, 13'h1FFF);
		clear_flags(0, 1);
		check_bit(power_cycle_flag, 1'b0);
	endtask
	task automatic enable_press_test();
		set_mode(0, 0, 0, 0);
		set_mode(0, 0, 1, 0);
		check_vec(reg_enable, 13'h1FFF);
		check_bit(reset_out_n, 1'b1);
		set_mode(0, 0, 0, 0);
		check_vec(reg_enable, 13'h1000);
	endtask
	task automatic reset_test();
		@(posedge core_clk);
		sys_rst <= 1'b1;
		cyc(2);
		check_vec(reg_enable, 13'h0000);
		check_bit(reset_out_n, 1'b0);
		check_bit(reset_out_oe, 1'b1);
		@(posedge core_clk);
		sys_rst <= 1'b0;
		cyc(4);
		check_bit(reset_out_n, 1'b0);
		cyc(1);
		check_bit(reset_out_n, 1'b1);
		cyc(4);
		check_vec(reg_enable, 13'h1000);
	endtask
	task automatic led_test(input logic [3:0] code);
		@(posedge core_clk);
		led_duty_code <= code;
		cyc(40);
		n = 0;
		repeat (32) begin
			cyc(1);
			n += int'(led_pwm_out);
		end
		check_vec(13'(n), 13'((int'(code) + 1) * 2));
	endtask

	// ======
	// main sequence
	initial begin
		cyc(5);
		check_vec(reg_enable, 13'h0000);
		check_bit(reset_out_oe, 1'b1);
		repeat (5) @(posedge core_clk);
		sys_rst <= 1'b0;
		wait_release(20);
		modes_test();
		short_press_test();
		long_press_test();
		enable_press_test();
		reset_test();
		led_test(4'h0);
		led_test(4'h7);
		led_test(4'hF);
		complete_run();
	end
endmodule
